// >>> shared/tmcap_map.svh
/*
 register map, field positions, reset values and timing counts of the
 16-bit timer/counter with input capture; assumes an APB slave with
 32-bit data, one aligned word per byte register.
*/
`ifndef TMCAP_MAP_SVH
`define TMCAP_MAP_SVH

`define TMCAP_OFF_CTRL_A      12'h000
`define TMCAP_OFF_CTRL_B      12'h004
`define TMCAP_OFF_CNT_LO      12'h008
`define TMCAP_OFF_CNT_HI      12'h00C
`define TMCAP_OFF_CAP_LO      12'h010
`define TMCAP_OFF_CAP_HI      12'h014
`define TMCAP_OFF_CMPA_LO     12'h018
`define TMCAP_OFF_CMPA_HI     12'h01C
`define TMCAP_OFF_CMPB_LO     12'h020
`define TMCAP_OFF_CMPB_HI     12'h024
`define TMCAP_OFF_FLAGS       12'h028
`define TMCAP_OFF_IMASK       12'h02C
`define TMCAP_OFF_CMP_CS      12'h030

`define TMCAP_A_WGM_LO        0
`define TMCAP_B_CS_LO         0
`define TMCAP_B_WGM_HI        3
`define TMCAP_B_EDGE          6
`define TMCAP_B_FILT          7
`define TMCAP_FLAG_OVF        0
`define TMCAP_FLAG_CAP        1
`define TMCAP_MASK_CAP        1
`define TMCAP_CS_CAPSEL       0
`define TMCAP_CS_ACO          1

`define TMCAP_RST_BYTE        8'h00
`define TMCAP_RST_WORD        16'h0000
`define TMCAP_MAX             16'hFFFF
`define TMCAP_FILT_SAMPLES    4
`define TMCAP_EXT_CS_FALL     3'h6
`define TMCAP_EXT_CS_RISE     3'h7

`endif

// >>> shared/tmcap_pkg.sv
/*
 types of the 16-bit timer/counter with input capture;
 assumes tmcap_map.svh for all numbers.
*/
package tmcap_pkg;
   typedef enum logic [1:0]
   {
      TMCAP_DIR_UP   = 2'b00,
      TMCAP_DIR_DOWN = 2'b01
   } tmcap_dir_t;

   typedef enum logic [1:0]
   {
      TMCAP_TOP_MAX = 2'b00,
      TMCAP_TOP_FIX = 2'b01,
      TMCAP_TOP_CAP = 2'b10,
      TMCAP_TOP_CMP = 2'b11
   } tmcap_top_t;
endpackage : tmcap_pkg

// >>> src/tmcap_timer.sv
/*
 16-bit up/down timer/counter with input capture, noise filter and a
 shared high-byte holding register, reached over APB.
 assumes: single clock clk, synchronous active-high reset, APB master,
 pins may be asynchronous to clk, prescaler strobe supplied from outside.
*/
// How it works
// - clock select picks internal or external source
// - 16-bit counter clears, counts up or down
// - upper count byte accesses the holding register
// - low read latches high; low write commits
// - select zero stops; count still accessible
// - cpu write beats clear and count
// - four-bit mode field split over controls
// - overflow flag set per mode, interrupt capable
// - matching edge on selected input triggers capture
// - capture copies full count into capture register
// - capture flag set with the copy
// - enabled flag interrupts; clears by ack/one
// - capture low read fills holding register
// - capture writable only in capture-top modes
// - select bit switches trigger to comparator
// - source switch may capture; software clears flag
// - inputs synchronised; filter adds four cycles
// - capture input off in capture-top modes
// - filter output changes after four equal samples
// - one holding byte for all 16-bit registers
`timescale 1ns/10ps
`include "tmcap_map.svh"

module tmcap_timer
   import tmcap_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // timer inputs
   input  wire logic        prescale_tick,
   input  wire logic        external_clock_pin,
   input  wire logic        capture_pin,
   input  wire logic        comparator_output,
   // interrupt service handshake
   input  wire logic        capture_irq_ack,
   input  wire logic        overflow_irq_ack,
   // interrupt requests
   output logic             capture_irq,
   output logic             overflow_irq
);

   // --- registers
   logic [7:0]  timer_control_a_reg;
   logic [7:0]  timer_control_b_reg;
   logic [7:0]  holding_reg;
   logic [15:0] count_value_reg;
   logic [15:0] capture_register_reg;
   logic [15:0] cmp_a_reg;
   logic [15:0] cmp_b_reg;
   logic        overflow_flag_reg;
   logic        capture_flag_reg;
   logic        capture_interrupt_enable_reg;
   logic        overflow_ie_reg;
   logic        comparator_capture_select_reg;
   tmcap_dir_t  dir_reg;
   logic [2:0]  ext_sync_reg;
   logic [2:0]  trig_sync_reg;
   logic [3:0]  filt_hist_reg;
   logic        filt_out_reg;
   logic        edge_prev_reg;

   // --- decode
   logic [3:0]  waveform_mode_field;
   logic [2:0]  clock_source_select;
   logic        wr;
   logic        rd;
   logic        timer_tick;
   logic [15:0] top_val;
   tmcap_top_t  top_kind;
   logic        dual_slope;
   logic        edge_in;
   logic        capture_now;
   logic [15:0] count_next;
   logic        ovf_event;
   tmcap_dir_t  dir_next;

   function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
      is_addr = (a == off);
   endfunction : is_addr

   // top value kind per mode; used for counting and capture access
   function automatic tmcap_top_t top_of(input logic [3:0] m);
      case (m)
         4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7: top_of = TMCAP_TOP_FIX;
         4'h8, 4'hA, 4'hC, 4'hE:             top_of = TMCAP_TOP_CAP;
         4'h4, 4'h9, 4'hB, 4'hF:             top_of = TMCAP_TOP_CMP;
         default:                            top_of = TMCAP_TOP_MAX;
      endcase
   endfunction : top_of

   assign waveform_mode_field = {timer_control_b_reg[`TMCAP_B_WGM_HI +: 2],
                                 timer_control_a_reg[`TMCAP_A_WGM_LO +: 2]};
   assign clock_source_select = timer_control_b_reg[`TMCAP_B_CS_LO +: 3];
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign top_kind = top_of(waveform_mode_field);
   assign dual_slope = (waveform_mode_field inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
                                                    4'hA, 4'hB});

   always_comb
   begin
      case (waveform_mode_field)
         4'h1, 4'h5: top_val = 16'h00FF;
         4'h2, 4'h6: top_val = 16'h01FF;
         4'h3, 4'h7: top_val = 16'h03FF;
         4'h8, 4'hA, 4'hC, 4'hE: top_val = capture_register_reg;
         4'h4, 4'h9, 4'hB, 4'hF: top_val = cmp_a_reg;
         default: top_val = `TMCAP_MAX;
      endcase
   end

   // external pin: two-stage sync, third stage for edge
   always_ff @(posedge clk)
   begin
      if (reset)
         ext_sync_reg <= 3'b000;
      else
         ext_sync_reg <= {ext_sync_reg[1:0], external_clock_pin};
   end

   // timer tick select; zero stops the counter
   always_comb
   begin
      case (clock_source_select)
         3'h0: timer_tick = 1'b0;
         `TMCAP_EXT_CS_FALL: timer_tick = ext_sync_reg[2] & ~ext_sync_reg[1];
         `TMCAP_EXT_CS_RISE: timer_tick = ~ext_sync_reg[2] & ext_sync_reg[1];
         3'h1: timer_tick = 1'b1;
         default: timer_tick = prescale_tick;
      endcase
   end

   // counting sequence per mode
   always_comb
   begin
      count_next = count_value_reg;
      dir_next = dir_reg;
      ovf_event = 1'b0;
      if (timer_tick)
      begin
         if (dual_slope)
         begin
            if (dir_reg == TMCAP_DIR_UP && count_value_reg >= top_val)
            begin
               dir_next = TMCAP_DIR_DOWN;
               count_next = count_value_reg - 16'h0001;
            end
            else if (dir_reg == TMCAP_DIR_DOWN && count_value_reg == `TMCAP_RST_WORD)
            begin
               dir_next = TMCAP_DIR_UP;
               count_next = count_value_reg + 16'h0001;
               ovf_event = 1'b1;
            end
            else if (dir_reg == TMCAP_DIR_UP)
               count_next = count_value_reg + 16'h0001;
            else
               count_next = count_value_reg - 16'h0001;
         end
         else if (count_value_reg == top_val && top_kind != TMCAP_TOP_MAX)
         begin
            count_next = `TMCAP_RST_WORD;
            ovf_event = (waveform_mode_field != 4'h4 && waveform_mode_field != 4'hC);
         end
         else
         begin
            count_next = count_value_reg + 16'h0001;
            ovf_event = (count_value_reg == `TMCAP_MAX);
         end
      end
   end

   // counter; cpu low-byte write commits holding byte and wins
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         count_value_reg <= `TMCAP_RST_WORD;
         dir_reg <= TMCAP_DIR_UP;
      end
      else if (wr && is_addr(paddr, `TMCAP_OFF_CNT_LO))
      begin
         count_value_reg <= {holding_reg, pwdata[7:0]};
         dir_reg <= dir_reg;
      end
      else
      begin
         count_value_reg <= count_next;
         dir_reg <= dir_next;
      end
   end

   // trigger path: source mux ahead of sync, so a source change can edge
   always_ff @(posedge clk)
   begin
      if (reset)
         trig_sync_reg <= 3'b000;
      else
         trig_sync_reg <= {trig_sync_reg[1:0],
                           comparator_capture_select_reg ? comparator_output
                                                         : capture_pin};
   end

   // four-sample filter, system clock only
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         filt_hist_reg <= 4'h0;
         filt_out_reg <= 1'b0;
      end
      else
      begin
         filt_hist_reg <= {filt_hist_reg[2:0], trig_sync_reg[1]};
         if (filt_hist_reg == 4'hF)
            filt_out_reg <= 1'b1;
         else if (filt_hist_reg == 4'h0)
            filt_out_reg <= 1'b0;
      end
   end

   assign edge_in = timer_control_b_reg[`TMCAP_B_FILT] ? filt_out_reg
                                                       : trig_sync_reg[2];

   always_ff @(posedge clk)
   begin
      if (reset)
         edge_prev_reg <= 1'b0;
      else
         edge_prev_reg <= edge_in;
   end

   assign capture_now = (top_kind != TMCAP_TOP_CAP)
                        && (edge_prev_reg != edge_in)
                        && (edge_in == timer_control_b_reg[`TMCAP_B_EDGE]);

   // capture register: hardware copy or cpu write in capture-top modes
   always_ff @(posedge clk)
   begin
      if (reset)
         capture_register_reg <= `TMCAP_RST_WORD;
      else if (capture_now)
         capture_register_reg <= count_value_reg;
      else if (wr && is_addr(paddr, `TMCAP_OFF_CAP_LO) && top_kind == TMCAP_TOP_CAP)
         capture_register_reg <= {holding_reg, pwdata[7:0]};
   end

   // compare registers written through the holding byte
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cmp_a_reg <= `TMCAP_RST_WORD;
         cmp_b_reg <= `TMCAP_RST_WORD;
      end
      else if (wr && is_addr(paddr, `TMCAP_OFF_CMPA_LO))
         cmp_a_reg <= {holding_reg, pwdata[7:0]};
      else if (wr && is_addr(paddr, `TMCAP_OFF_CMPB_LO))
         cmp_b_reg <= {holding_reg, pwdata[7:0]};
   end

   // one shared holding byte for every 16-bit register
   always_ff @(posedge clk)
   begin
      if (reset)
         holding_reg <= `TMCAP_RST_BYTE;
      else if (wr && (is_addr(paddr, `TMCAP_OFF_CNT_HI) || is_addr(paddr, `TMCAP_OFF_CAP_HI)
                      || is_addr(paddr, `TMCAP_OFF_CMPA_HI)
                      || is_addr(paddr, `TMCAP_OFF_CMPB_HI)))
         holding_reg <= pwdata[7:0];
      else if (rd && is_addr(paddr, `TMCAP_OFF_CNT_LO))
         holding_reg <= count_value_reg[15:8];
      else if (rd && is_addr(paddr, `TMCAP_OFF_CAP_LO))
         holding_reg <= capture_register_reg[15:8];
   end

   // control bytes
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         timer_control_a_reg <= `TMCAP_RST_BYTE;
         timer_control_b_reg <= `TMCAP_RST_BYTE;
         capture_interrupt_enable_reg <= 1'b0;
         overflow_ie_reg <= 1'b0;
         comparator_capture_select_reg <= 1'b0;
      end
      else if (wr)
      begin
         if (is_addr(paddr, `TMCAP_OFF_CTRL_A))
            timer_control_a_reg <= pwdata[7:0];
         if (is_addr(paddr, `TMCAP_OFF_CTRL_B))
            timer_control_b_reg <= pwdata[7:0];
         if (is_addr(paddr, `TMCAP_OFF_IMASK))
         begin
            capture_interrupt_enable_reg <= pwdata[`TMCAP_MASK_CAP];
            overflow_ie_reg <= pwdata[`TMCAP_FLAG_OVF];
         end
         if (is_addr(paddr, `TMCAP_OFF_CMP_CS))
            comparator_capture_select_reg <= pwdata[`TMCAP_CS_CAPSEL];
      end
   end

   // flags: set wins over write-one clear and over service ack
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         capture_flag_reg <= 1'b0;
         overflow_flag_reg <= 1'b0;
      end
      else
      begin
         if (capture_now)
            capture_flag_reg <= 1'b1;
         else if ((wr && is_addr(paddr, `TMCAP_OFF_FLAGS) && pwdata[`TMCAP_FLAG_CAP])
                  || (capture_irq_ack && capture_irq))
            capture_flag_reg <= 1'b0;
         if (ovf_event)
            overflow_flag_reg <= 1'b1;
         else if ((wr && is_addr(paddr, `TMCAP_OFF_FLAGS) && pwdata[`TMCAP_FLAG_OVF])
                  || (overflow_irq_ack && overflow_irq))
            overflow_flag_reg <= 1'b0;
      end
   end

   // interrupt requests one cycle behind their flags
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         capture_irq <= 1'b0;
         overflow_irq <= 1'b0;
      end
      else
      begin
         capture_irq <= capture_flag_reg && capture_interrupt_enable_reg
                        && !(capture_irq_ack && capture_irq);
         overflow_irq <= overflow_flag_reg && overflow_ie_reg
                         && !(overflow_irq_ack && overflow_irq);
      end
   end

   // apb: zero-wait, read data registered in setup so it stands in access
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && (paddr > `TMCAP_OFF_CMP_CS || paddr[1:0] != 2'b00);
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite)
         begin
            case (paddr)
               `TMCAP_OFF_CTRL_A:  prdata <= {24'h00_0000, timer_control_a_reg};
               `TMCAP_OFF_CTRL_B:  prdata <= {24'h00_0000, timer_control_b_reg};
               `TMCAP_OFF_CNT_LO:  prdata <= {24'h00_0000, count_value_reg[7:0]};
               `TMCAP_OFF_CAP_LO:  prdata <= {24'h00_0000, capture_register_reg[7:0]};
               `TMCAP_OFF_CNT_HI,
               `TMCAP_OFF_CAP_HI:  prdata <= {24'h00_0000, holding_reg};
               `TMCAP_OFF_CMPA_LO: prdata <= {24'h00_0000, cmp_a_reg[7:0]};
               `TMCAP_OFF_CMPA_HI: prdata <= {24'h00_0000, cmp_a_reg[15:8]};
               `TMCAP_OFF_CMPB_LO: prdata <= {24'h00_0000, cmp_b_reg[7:0]};
               `TMCAP_OFF_CMPB_HI: prdata <= {24'h00_0000, cmp_b_reg[15:8]};
               `TMCAP_OFF_FLAGS:   prdata <= {30'h0000_0000, capture_flag_reg,
                                              overflow_flag_reg};
               `TMCAP_OFF_IMASK:   prdata <= {30'h0000_0000, capture_interrupt_enable_reg,
                                              overflow_ie_reg};
               `TMCAP_OFF_CMP_CS:  prdata <= {30'h0000_0000, comparator_output,
                                              comparator_capture_select_reg};
               default:            prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule : tmcap_timer

// >>> testbench/tmcap_timer_props.sv
/*
 concurrent checks on the apb and interrupt ports of tmcap_timer.
 assumes a master that follows each setup cycle with its access cycle.
*/
`timescale 1ns/10ps

module tmcap_timer_props
(
   // clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // interrupts
   input wire logic        capture_irq_ack,
   input wire logic        overflow_irq_ack,
   input wire logic        capture_irq,
   input wire logic        overflow_irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   property p_ready_next;
      psel && !penable |=> pready;
   endproperty
   a_ready_next: assert property (p_ready_next) else $error("no ready after setup");

   property p_ready_only;
      pready |-> psel && penable && $past(psel && !penable);
   endproperty
   a_ready_only: assert property (p_ready_only) else $error("ready outside access");

   property p_err_map;
      psel && !penable && (paddr > 12'h030 || paddr[1:0] != 2'b00) |=> pslverr;
   endproperty
   a_err_map: assert property (p_err_map) else $error("unmapped not refused");

   property p_err_ok;
      psel && !penable && paddr <= 12'h030 && paddr[1:0] == 2'b00 |=> !pslverr;
   endproperty
   a_err_ok: assert property (p_err_ok) else $error("mapped access refused");

   property p_data_idle;
      !pready |-> prdata == 32'h0000_0000;
   endproperty
   a_data_idle: assert property (p_data_idle) else $error("read data outside access");

   property p_byte_read;
      pready && !pwrite |-> prdata[31:8] == 24'h00_0000;
   endproperty
   a_byte_read: assert property (p_byte_read) else $error("read wider than a byte");

   property p_err_zero;
      pready && pslverr |-> prdata == 32'h0000_0000;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("refused read not zero");

   property p_cap_ack;
      capture_irq && capture_irq_ack |=> !capture_irq;
   endproperty
   a_cap_ack: assert property (p_cap_ack) else $error("capture irq kept after ack");

   property p_ovf_ack;
      overflow_irq && overflow_irq_ack |=> !overflow_irq;
   endproperty
   a_ovf_ack: assert property (p_ovf_ack) else $error("overflow irq kept after ack");
endmodule : tmcap_timer_props

bind tmcap_timer tmcap_timer_props u_tmcap_timer_props
(
   .clk, .reset, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr,
   .capture_irq_ack, .overflow_irq_ack, .capture_irq, .overflow_irq
);

// >>> testbench/tmcap_pins.sv
/*
 model of the pins around the timer: capture pin, comparator output and
 external clock pin. assumes the bench calls its tasks just after an edge.
*/
`timescale 1ns/10ps

module tmcap_pins
(
   // clock
   input wire logic clk,
   // pins toward the timer
   output logic     capture_pin,
   output logic     comparator_output,
   output logic     external_clock_pin
);
   initial
   begin
      capture_pin        = 1'b0;
      comparator_output  = 1'b0;
      external_clock_pin = 1'b0;
   end

   // set both trigger sources, then hold them
   task automatic drive(input logic cap, input logic cmp, input int hold);
      capture_pin       <= cap;
      comparator_output <= cmp;
      repeat (hold) @(posedge clk);
   endtask : drive

   // slow edges: the pin passes a three-flop synchroniser
   task automatic ext_edges(input int n);
      repeat (2 * n)
      begin
         external_clock_pin <= ~external_clock_pin;
         repeat (4) @(posedge clk);
      end
   endtask : ext_edges
endmodule : tmcap_pins

// >>> testbench/tmcap_timer_bench.sv
/*
 self-checking bench of tmcap_timer: byte accesses, capture, filter,
 overflow and external counting. assumes tmcap_map.svh and tmcap_pins.
*/
`timescale 1ns/10ps
`include "tmcap_map.svh"

module tmcap_timer_bench;
   localparam logic [11:0] A_CA = `TMCAP_OFF_CTRL_A;
   localparam logic [11:0] A_CB = `TMCAP_OFF_CTRL_B;
   localparam logic [11:0] A_CL = `TMCAP_OFF_CNT_LO;
   localparam logic [11:0] A_CH = `TMCAP_OFF_CNT_HI;
   localparam logic [11:0] A_KL = `TMCAP_OFF_CAP_LO;
   localparam logic [11:0] A_KH = `TMCAP_OFF_CAP_HI;
   localparam logic [11:0] A_FL = `TMCAP_OFF_FLAGS;
   localparam logic [11:0] A_EN = `TMCAP_OFF_IMASK;
   localparam logic [11:0] A_CS = `TMCAP_OFF_CMP_CS;
   logic        clk, reset, psel, penable, pwrite, pready, pslverr, rerr;
   logic        prescale_tick, capture_pin, comparator_output, external_clock_pin;
   logic        capture_irq_ack, overflow_irq_ack, capture_irq, overflow_irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  rdat;
   int          bad_count, samples_checked;

   tmcap_timer u_tmcap_timer
   (
      .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr, .prescale_tick, .external_clock_pin, .capture_pin,
      .comparator_output, .capture_irq_ack, .overflow_irq_ack, .capture_irq,
      .overflow_irq
   );
   tmcap_pins u_tmcap_pins (.clk, .capture_pin, .comparator_output, .external_clock_pin);

   always #10 clk = ~clk;

   task automatic complete_run;
      if (bad_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one transfer, then one idle edge so strobes never change twice at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h00_0000, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         bad_count++;
         complete_run;
      end
      rdat    = prdata[7:0];
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rc(input logic [11:0] a, input logic [7:0] e, input string what);
      apb(1'b0, a, 8'h00);
      chk(what, e, rdat);
   endtask : rc

   task automatic cap_case(input logic [7:0] cb, input logic [7:0] hi, input logic c,
                           input logic a);
      wr(A_CB, cb);
      wr(A_CH, hi);
      wr(A_CL, 8'h00);
      wr(A_FL, 8'h03);
      u_tmcap_pins.drive(c, a, 16);
      rc(A_FL, 8'h02, "capture flag");
      rc(A_KL, 8'h00, "capture lo");
      rc(A_KH, hi, "capture hi");
   endtask : cap_case

   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {prescale_tick, capture_irq_ack, overflow_irq_ack} = '0;
      bad_count = 0;
      samples_checked = 0;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rc(A_CB, 8'h00, "ctrl b reset");
      rc(A_CL, 8'h00, "count reset");
      wr(A_CH, 8'h12);
      wr(A_CL, 8'h34);
      repeat (5) @(posedge clk);
      rc(A_CL, 8'h34, "count lo stopped");
      rc(A_CH, 8'h12, "count hi");
      // one high byte written once serves two registers
      wr(A_CH, 8'h56);
      wr(A_CL, 8'h00);
      wr(`TMCAP_OFF_CMPA_LO, 8'h11);
      rc(`TMCAP_OFF_CMPA_HI, 8'h56, "compare hi shared");
      // write lands while counting every clock
      wr(A_CB, 8'h01);
      wr(A_CH, 8'h77);
      wr(A_CL, 8'h00);
      wr(A_CB, 8'h00);
      apb(1'b0, A_CL, 8'h00);
      rc(A_CH, 8'h77, "count hi after running write");
      wr(A_CH, 8'hFF);
      wr(A_CL, 8'hF0);
      wr(A_EN, 8'h01);
      wr(A_CB, 8'h01);
      repeat (30) @(posedge clk);
      wr(A_CB, 8'h00);
      rc(A_FL, 8'h01, "overflow flag");
      chk("overflow irq", 8'h01, {7'h00, overflow_irq});
      overflow_irq_ack <= 1'b1;
      @(posedge clk);
      overflow_irq_ack <= 1'b0;
      rc(A_FL, 8'h00, "overflow acked");
      cap_case(8'h40, 8'h01, 1'b1, 1'b0);
      wr(A_EN, 8'h02);
      repeat (2) @(posedge clk);
      chk("capture irq", 8'h01, {7'h00, capture_irq});
      capture_irq_ack <= 1'b1;
      @(posedge clk);
      capture_irq_ack <= 1'b0;
      rc(A_FL, 8'h00, "capture acked");
      cap_case(8'h00, 8'h02, 1'b0, 1'b0);
      wr(A_FL, 8'h02);
      rc(A_FL, 8'h00, "capture cleared by one");
      wr(A_CS, 8'h01);
      cap_case(8'h40, 8'h03, 1'b0, 1'b1);
      wr(A_CS, 8'h00);
      // short pulse must not survive the filter
      wr(A_CB, 8'hC0);
      u_tmcap_pins.drive(1'b0, 1'b0, 4);
      wr(A_FL, 8'h03);
      u_tmcap_pins.drive(1'b1, 1'b0, 2);
      u_tmcap_pins.drive(1'b0, 1'b0, 14);
      rc(A_FL, 8'h00, "glitch filtered");
      cap_case(8'hC0, 8'h04, 1'b1, 1'b0);
      wr(A_CB, 8'h00);
      wr(A_KH, 8'h99);
      wr(A_KL, 8'h88);
      rc(A_KL, 8'h00, "capture write refused lo");
      rc(A_KH, 8'h04, "capture write refused hi");
      // mode 14 splits its field over both controls
      wr(A_CA, 8'h02);
      wr(A_CB, 8'h18);
      wr(A_KH, 8'h99);
      wr(A_KL, 8'h88);
      rc(A_KL, 8'h88, "capture top lo");
      rc(A_KH, 8'h99, "capture top hi");
      wr(A_FL, 8'h03);
      u_tmcap_pins.drive(1'b0, 1'b0, 16);
      rc(A_FL, 8'h00, "no capture in top mode");
      // dual slope: four prescaler ticks turn at top and count back
      wr(A_CA, 8'h01);
      wr(A_CH, 8'h00);
      wr(A_CL, 8'hFE);
      wr(A_CB, 8'h02);
      repeat (4)
      begin
         prescale_tick <= 1'b1;
         @(posedge clk);
         prescale_tick <= 1'b0;
         @(posedge clk);
      end
      wr(A_CB, 8'h00);
      rc(A_CL, 8'hFC, "dual slope down count");
      wr(A_CA, 8'h00);
      wr(A_CB, 8'h00);
      wr(A_CH, 8'h00);
      wr(A_CL, 8'h00);
      wr(A_CB, 8'h07);
      u_tmcap_pins.ext_edges(4);
      repeat (8) @(posedge clk);
      wr(A_CB, 8'h00);
      rc(A_CL, 8'h04, "external count");
      apb(1'b0, 12'h040, 8'h00);
      chk("unmapped error", 8'h01, {7'h00, rerr});
      chk("unmapped data", 8'h00, rdat);
      complete_run;
   end
endmodule : tmcap_timer_bench
